// ---- src/pos_pkg.sv ----
// Constants, modes and carriers for the output-shaping stage.
// Assumes one 200 MHz clock and a classic Wishbone register bus.
package pos_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets, byte addresses on the bus.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_BURNOUT = 8'h08;
  localparam logic [7:0] OFS_RAMP = 8'h0c;
  localparam logic [7:0] OFS_LSP = 8'h10;
  localparam logic [7:0] OFS_MVFIX = 8'h14;
  localparam logic [7:0] OFS_MVLIM = 8'h18;
  localparam logic [7:0] OFS_RATE = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_SETPOINT = 8'h24;

  // Control register fields, then field offsets in the period, fixed-MV and limit registers.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_METH = 1;
  localparam int CTRL_PULSE = 3;
  localparam int CTRL_POSPROP = 4;
  localparam int CTRL_RSP_EN = 5;
  localparam int CTRL_SELF_TUNE = 6;
  localparam int CTRL_HOUR = 7;
  localparam int CTRL_VALVE = 8;
  localparam int PER_COOL = 8;
  localparam int FIX_ERR = 16;
  localparam int LIM_LO = 16;

  // Reset values.
  localparam logic [31:0] CTRL_RST = 32'h0000_0108;
  localparam logic [31:0] PERIOD_RST = 32'h0000_1414;
  localparam logic [31:0] MVLIM_RST = 32'hffce_041a;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;

  // Ranges, in 0.1 percent, 0.1 ampere and whole seconds.
  localparam logic [6:0] PER_MIN = 7'h01;
  localparam logic [6:0] PER_MAX = 7'h63;
  localparam logic signed [16:0] MV_MAX = 17'sh0041a;
  localparam logic signed [16:0] MV_STD_MIN = -17'sh00032;
  localparam logic signed [16:0] MV_HC_MIN = -17'sh0041a;
  localparam logic signed [16:0] MV_FULL = 17'sh003e8;
  localparam logic signed [16:0] MV_STEP = 17'sh00001;
  localparam logic [8:0] HB_MAX = 9'h1f4;
  localparam logic [9:0] RATE_MAX = 10'h3e8;
  localparam logic [13:0] RAMP_MAX = 14'h270f;

  // Time base.
  localparam longint CLK_HZ = 200_000_000;
  localparam longint CS_TIME_MS = 10;
  localparam int CYC_PER_CS = int'(CLK_HZ / 1000 * CS_TIME_MS);
  localparam logic [6:0] CS_PER_S = 7'h64;
  localparam logic [11:0] S_PER_MIN = 12'h03c;
  localparam logic [11:0] S_PER_HOUR = 12'he10;
  localparam logic [17:0] DUTY_DIV = 18'h0000a;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {METH_STD, METH_HC, METH_ADV, METH_ONOFF}
    pos_meth_t;
  typedef enum logic [1:0] {VALVE_CLOSE, VALVE_HOLD, VALVE_OPEN}
    pos_valve_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pos_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } pos_wb_rsp_t;

  typedef struct packed {
    logic signed [11:0] mv_calc;
    logic [9:0] heater_current;
    logic sp_event;
    logic input_error;
    logic signed [15:0] remote_setpoint;
  } pos_proc_in_t;

endpackage

// ---- src/pos_top.sv ----
// Output-shaping stage: setpoint select and ramp, MV limits, rate limit,
// fixed stop and error outputs, time-proportional pulses, burnout alarm.
// Assumes a classic Wishbone master and inputs synchronous to clk_i.
//
// Functional notes
// R01: Heat and cool pulse periods are 1 to 99 seconds, default 20.
// R02: Pulsing only for pulse outputs and advanced, standard or heat/cool.
// R03: Standard control uses the heat period only; cool side is idle.
// R04: Heat/cool times each side with its own period.
// R05: Burnout alarm when heater current is below threshold 0.0 to 50.0 A.
// R06: Threshold 0.0 forces alarm off, 50.0 forces it on.
// R07: Event on selects remote setpoint, off selects local, local default.
// R08: Remote selection only with remote enabled and self-tuning off.
// R09: Ramp limits setpoint change per time unit; zero disables ramping.
// R10: Ramp value 0 to 9999 is kept apart from minute or hour unit.
// R11: Stopped standard device outputs the stop MV.
// R12: Input error outputs the error MV.
// R13: Position type applies close, hold or open on stop and error.
// R14: Fixed MVs span -5..105 standard, -105..105 heat/cool, default 0.
// R15: Computed MV beyond a limit is output as that limit.
// R16: Standard limits: lower+0.1 <= upper <= 105, -5 <= lower.
// R17: Heat/cool limits: upper 0 to 105, lower -105 to 0.
// R18: Position-proportional control ignores the MV limits.
// R19: Output moves at most the rate limit per second; zero disables.
// R20: Pulse on-time within a period is proportional to the MV.
`timescale 1ns/100ps
module pos_top #(
  parameter int CYC_PER_CS = pos_pkg::CYC_PER_CS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pos_pkg::pos_wb_req_t wb_req_i,
  output pos_pkg::pos_wb_rsp_t wb_rsp_o,
  input wire pos_pkg::pos_proc_in_t proc_i,
  output logic heat_out_o,
  output logic cool_out_o,
  output logic heater_burnout_alarm_o,
  output logic valve_open_o,
  output logic valve_close_o,
  output logic signed [11:0] mv_out_o,
  output logic signed [15:0] setpoint_o
);
  import pos_pkg::*;

  localparam int DIV_W = $clog2(CYC_PER_CS + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Byte-lane merge for register writes.
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Saturating clamp on percent-tenths values.
  function automatic logic signed [16:0] clamp(input logic signed [16:0] v,
                                               input logic signed [16:0] lo,
                                               input logic signed [16:0] hi);
    logic signed [16:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // Period field clamp into the legal seconds range.
  function automatic logic [6:0] per_clamp(input logic [6:0] p);
    logic [6:0] r;
    r = p;
    if (p < PER_MIN) begin
      r = PER_MIN;
    end else if (p > PER_MAX) begin
      r = PER_MAX;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file and Wishbone slave.

  logic [31:0] ctrl_q;
  logic [31:0] period_q;
  logic [31:0] burnout_q;
  logic [31:0] ramp_q;
  logic [31:0] lsp_q;
  logic [31:0] mvfix_q;
  logic [31:0] mvlim_q;
  logic [31:0] rate_q;
  logic [31:0] rd_d;
  logic ack_q;
  logic [31:0] rdat_q;
  logic req;
  logic signed [16:0] mv_q;
  logic signed [15:0] sp_q;
  logic alarm_q;
  logic remote_act;
  logic stopped;

  // The ack drop makes every access exactly one request long.
  assign req = wb_req_i.cyc & wb_req_i.stb & ~ack_q;

  // Software writes, one process for the whole register set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      period_q <= PERIOD_RST; // R01
      burnout_q <= ZERO_RST;
      ramp_q <= ZERO_RST;
      lsp_q <= ZERO_RST;
      mvfix_q <= ZERO_RST; // R14
      mvlim_q <= MVLIM_RST;
      rate_q <= ZERO_RST;
    end else if (req && wb_req_i.we) begin
      unique case (wb_req_i.adr)
        OFS_CTRL: ctrl_q <= merge(ctrl_q, wb_req_i.dat, wb_req_i.sel);
        OFS_PERIOD: period_q <= merge(period_q, wb_req_i.dat, wb_req_i.sel);
        OFS_BURNOUT: burnout_q <= merge(burnout_q, wb_req_i.dat,
                                        wb_req_i.sel);
        OFS_RAMP: ramp_q <= merge(ramp_q, wb_req_i.dat, wb_req_i.sel);
        OFS_LSP: lsp_q <= merge(lsp_q, wb_req_i.dat, wb_req_i.sel);
        OFS_MVFIX: mvfix_q <= merge(mvfix_q, wb_req_i.dat, wb_req_i.sel);
        OFS_MVLIM: mvlim_q <= merge(mvlim_q, wb_req_i.dat, wb_req_i.sel);
        OFS_RATE: rate_q <= merge(rate_q, wb_req_i.dat, wb_req_i.sel);
        default: ;
      endcase
    end
  end

  // Read mux; unmapped offsets read as zero and still acknowledge.
  always_comb begin
    rd_d = '0;
    unique case (wb_req_i.adr)
      OFS_CTRL: rd_d = ctrl_q;
      OFS_PERIOD: rd_d = period_q;
      OFS_BURNOUT: rd_d = burnout_q;
      OFS_RAMP: rd_d = ramp_q;
      OFS_LSP: rd_d = lsp_q;
      OFS_MVFIX: rd_d = mvfix_q;
      OFS_MVLIM: rd_d = mvlim_q;
      OFS_RATE: rd_d = rate_q;
      OFS_STATUS: rd_d = {4'h0, mv_q[11:0], 12'h000,
                          proc_i.input_error, stopped, remote_act, alarm_q};
      OFS_SETPOINT: rd_d = {{16{sp_q[15]}}, sp_q};
      default: rd_d = '0;
    endcase
  end

  // One-cycle acknowledge with registered read data.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= req;
      if (req) begin
        rdat_q <= rd_d;
      end
    end
  end

  assign wb_rsp_o = '{ack: ack_q, dat: rdat_q};

  ////////////////////////////////////////////////////////////////////////////
  // Field decode.

  pos_meth_t meth;
  pos_valve_t valve;
  logic pulse_type;
  logic posprop;
  logic hour_unit;
  logic [13:0] ramp_v;
  logic [9:0] rate_v;
  logic [8:0] hb_thr;

  assign meth = pos_meth_t'(ctrl_q[CTRL_METH +: 2]);
  assign valve = pos_valve_t'(ctrl_q[CTRL_VALVE +: 2]);
  assign pulse_type = ctrl_q[CTRL_PULSE];
  assign posprop = ctrl_q[CTRL_POSPROP];
  assign hour_unit = ctrl_q[CTRL_HOUR];
  assign stopped = ~ctrl_q[CTRL_RUN];
  assign ramp_v = (ramp_q[13:0] > RAMP_MAX) ? RAMP_MAX : ramp_q[13:0]; // R10
  assign rate_v = (rate_q[9:0] > RATE_MAX) ? RATE_MAX : rate_q[9:0];
  assign hb_thr = (burnout_q[8:0] > HB_MAX) ? HB_MAX : burnout_q[8:0];

  ////////////////////////////////////////////////////////////////////////////
  // Time base: 10 ms ticks, seconds and ramp units as enable pulses.

  logic [DIV_W-1:0] div_q;
  logic [6:0] cs_q;
  logic [11:0] unit_q;
  logic [11:0] unit_len;
  logic cs_tick_q;
  logic sec_tick_q;
  logic unit_tick_q;

  // Unit changes only the divisor, so the ramp value keeps its meaning.
  assign unit_len = hour_unit ? S_PER_HOUR : S_PER_MIN; // R10

  // Clock divider chain.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= '0;
      cs_q <= '0;
      unit_q <= '0;
      cs_tick_q <= 1'b0;
      sec_tick_q <= 1'b0;
      unit_tick_q <= 1'b0;
    end else begin
      cs_tick_q <= (div_q == DIV_W'(CYC_PER_CS - 1));
      div_q <= (div_q == DIV_W'(CYC_PER_CS - 1)) ? '0 : div_q + 1'b1;
      sec_tick_q <= 1'b0;
      unit_tick_q <= 1'b0;
      if (cs_tick_q) begin
        cs_q <= (cs_q == CS_PER_S - 7'h01) ? '0 : cs_q + 7'h01;
        sec_tick_q <= (cs_q == CS_PER_S - 7'h01);
      end
      if (sec_tick_q) begin
        // A shorter unit chosen mid-count wraps at once, no long wait.
        unit_q <= (unit_q >= unit_len - 12'h001) ? '0 : unit_q + 12'h001;
        unit_tick_q <= (unit_q >= unit_len - 12'h001);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setpoint source and ramp.

  logic signed [15:0] sp_target;
  logic signed [16:0] sp_diff;
  logic signed [16:0] ramp_s;

  // Self-tuning locks the source to local whatever the event says.
  assign remote_act = ctrl_q[CTRL_RSP_EN] & ~ctrl_q[CTRL_SELF_TUNE]
                      & proc_i.sp_event; // R08
  assign sp_target = remote_act ? proc_i.remote_setpoint
                                : lsp_q[15:0]; // R07
  assign sp_diff = 17'(sp_target) - 17'(sp_q);
  assign ramp_s = $signed({3'b000, ramp_v});

  // Ramp steps once per time unit by at most the ramp value.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp_q <= '0;
    end else if (ramp_v == '0) begin
      sp_q <= sp_target; // R09
    end else if (unit_tick_q) begin
      if (sp_diff > ramp_s) begin
        sp_q <= 16'(17'(sp_q) + ramp_s); // R09
      end else if (sp_diff < -ramp_s) begin
        sp_q <= 16'(17'(sp_q) - ramp_s); // R09
      end else begin
        sp_q <= sp_target;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Manipulated variable: fixed values, limits and rate limit.

  logic signed [16:0] lim_lo;
  logic signed [16:0] lim_hi;
  logic signed [16:0] fix_lo;
  logic signed [16:0] mv_calc;
  logic signed [16:0] mv_tgt;
  logic signed [16:0] mv_diff;
  logic signed [16:0] rate_s;
  logic fixed;

  assign mv_calc = 17'(proc_i.mv_calc);
  assign fixed = stopped | proc_i.input_error;
  assign fix_lo = (meth == METH_HC) ? MV_HC_MIN : MV_STD_MIN;
  assign rate_s = $signed({7'h00, rate_v});
  assign mv_diff = mv_tgt - mv_q;

  // Effective limits; out-of-range settings are pulled into range.
  always_comb begin
    if (meth == METH_HC) begin
      lim_hi = clamp(17'($signed(mvlim_q[15:0])), '0, MV_MAX); // R17
      lim_lo = clamp(17'($signed(mvlim_q[LIM_LO +: 16])),
                     MV_HC_MIN, '0); // R17
    end else begin
      lim_lo = clamp(17'($signed(mvlim_q[LIM_LO +: 16])),
                     MV_STD_MIN, MV_MAX - MV_STEP); // R16
      lim_hi = clamp(17'($signed(mvlim_q[15:0])),
                     lim_lo + MV_STEP, MV_MAX); // R16
    end
  end

  // Error outranks stop, since a bad input makes the stop value moot.
  always_comb begin
    if (proc_i.input_error) begin
      mv_tgt = clamp(17'($signed(mvfix_q[FIX_ERR +: 16])),
                     fix_lo, MV_MAX); // R12 R14
    end else if (stopped) begin
      mv_tgt = clamp(17'($signed(mvfix_q[15:0])), fix_lo, MV_MAX); // R11
    end else if (posprop) begin
      mv_tgt = mv_calc; // R18
    end else begin
      mv_tgt = clamp(mv_calc, lim_lo, lim_hi); // R15
    end
  end

  // Fixed values take effect at once unless the position type holds; computed ones obey the rate limit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mv_q <= '0;
    end else if (posprop && fixed && valve == VALVE_HOLD) begin
      mv_q <= mv_q; // R13
    end else if (fixed || rate_v == '0) begin
      mv_q <= mv_tgt; // R19
    end else if (sec_tick_q) begin
      mv_q <= clamp(mv_diff, -rate_s, rate_s) + mv_q; // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Valve drive for the position-proportional type.

  // Normal running drives the valve toward the target position.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valve_open_o <= 1'b0;
      valve_close_o <= 1'b0;
    end else if (!posprop) begin
      valve_open_o <= 1'b0;
      valve_close_o <= 1'b0;
    end else if (fixed) begin
      valve_open_o <= (valve == VALVE_OPEN); // R13
      valve_close_o <= (valve == VALVE_CLOSE); // R13
    end else begin
      valve_open_o <= (mv_diff > 17'sh00000);
      valve_close_o <= (mv_diff < 17'sh00000);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time-proportional outputs, heat side 0 and cool side 1.

  logic pulse_ok;
  logic side_en [2];
  logic [10:0] duty [2];
  logic out_q [2];

  // On/off control and non-pulse outputs switch as a plain level.
  assign pulse_ok = pulse_type & (meth != METH_ONOFF) & ~posprop; // R02
  assign side_en[0] = ~posprop;
  assign side_en[1] = ~posprop & (meth == METH_HC); // R03 R04

  // Duty in tenths of percent, capped at full on.
  // A signed zero keeps the sign test signed; '0 would make it unsigned.
  always_comb begin
    duty[0] = (mv_q > 17'sh00000) ? 11'(clamp(mv_q, '0, MV_FULL)) : '0;
    duty[1] = (mv_q < 17'sh00000) ? 11'(clamp(-mv_q, '0, MV_FULL)) : '0;
  end

  for (genvar g = 0; g < 2; g++) begin : g_side
    logic [6:0] per;
    logic [13:0] len;
    logic [13:0] pcnt_q;
    logic on;

    assign per = per_clamp(period_q[g*PER_COOL +: 7]); // R01
    assign len = 14'(per) * 14'(CS_PER_S);
    // On while elapsed time stays below duty times period.
    assign on = (18'(pcnt_q) * DUTY_DIV) < (18'(duty[g]) * 18'(per)); // R20

    // Period counter in 10 ms steps, restarting each period.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pcnt_q <= '0;
      end else if (cs_tick_q) begin
        pcnt_q <= (pcnt_q >= len - 14'h0001) ? '0 : pcnt_q + 14'h0001;
      end
    end

    // Output stage per side.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        out_q[g] <= 1'b0;
      end else if (!side_en[g]) begin
        out_q[g] <= 1'b0; // R03
      end else if (pulse_ok) begin
        out_q[g] <= on; // R04 R20
      end else begin
        out_q[g] <= (duty[g] != '0);
      end
    end
  end

  assign heat_out_o = out_q[0];
  assign cool_out_o = out_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Heater burnout alarm.

  // End points of the threshold range force the alarm regardless of load.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_q <= 1'b0;
    end else if (hb_thr == '0) begin
      alarm_q <= 1'b0; // R06
    end else if (hb_thr == HB_MAX) begin
      alarm_q <= 1'b1; // R06
    end else begin
      alarm_q <= (proc_i.heater_current < 10'(hb_thr)); // R05
    end
  end

  assign heater_burnout_alarm_o = alarm_q;
  assign mv_out_o = mv_q[11:0];
  assign setpoint_o = sp_q;

endmodule // pos_top

// ---- testbench/pos_top_assertions.sv ----
// Concurrent checks on the ports of the output-shaping stage.
// Assumes one clock, synchronous active-high reset, bound into pos_top.
`timescale 1ns/100ps
module pos_top_assertions #(
  parameter int CYC_PER_CS = pos_pkg::CYC_PER_CS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pos_pkg::pos_wb_req_t wb_req_i,
  input wire pos_pkg::pos_wb_rsp_t wb_rsp_o,
  input wire pos_pkg::pos_proc_in_t proc_i,
  input wire logic heat_out_o,
  input wire logic cool_out_o,
  input wire logic heater_burnout_alarm_o,
  input wire logic valve_open_o,
  input wire logic valve_close_o,
  input wire logic signed [11:0] mv_out_o,
  input wire logic signed [15:0] setpoint_o
);
  import pos_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // All checks share the one clock; reset silences them.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A bus request and the single-cycle answer that must follow it.
  sequence s_req;
    wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  endsequence
  sequence s_ack_pulse;
    wb_rsp_o.ack ##1 !wb_rsp_o.ack;
  endsequence

  property p_take;
    s_req |=> s_ack_pulse;
  endproperty
  a_take: assert property (p_take) else $error("ack missing or too long");

  property p_no_spur;
    $rose(wb_rsp_o.ack) |-> $past(wb_req_i.cyc && wb_req_i.stb);
  endproperty
  a_no_spur: assert property (p_no_spur) else $error("ack without request");

  // The alarm may only move after a current change or any acknowledged bus access.
  property p_alarm_cause;
    $changed(heater_burnout_alarm_o) |->
      ($past(proc_i.heater_current, 1) != $past(proc_i.heater_current, 2))
      || $past(wb_rsp_o.ack, 1) || $past(wb_rsp_o.ack, 2)
      || $past(wb_rsp_o.ack, 3);
  endproperty
  a_alarm_cause: assert property (p_alarm_cause)
    else $error("alarm moved without cause");

  // Heating only for a positive MV, cooling only for a negative one.
  property p_heat_sign;
    heat_out_o |-> (mv_out_o > 0) || ($past(mv_out_o) > 0);
  endproperty
  a_heat_sign: assert property (p_heat_sign)
    else $error("heat on with MV not positive");

  property p_cool_sign;
    cool_out_o |-> (mv_out_o < 0) || ($past(mv_out_o) < 0);
  endproperty
  a_cool_sign: assert property (p_cool_sign)
    else $error("cool on with MV not negative");

  property p_valve_excl;
    !(valve_open_o && valve_close_o);
  endproperty
  a_valve_excl: assert property (p_valve_excl)
    else $error("valve open and close together");

  property p_valve_quiet;
    (valve_open_o || valve_close_o) |-> !heat_out_o && !cool_out_o;
  endproperty
  a_valve_quiet: assert property (p_valve_quiet)
    else $error("pulse output during valve drive");

  property p_mv_range;
    (mv_out_o >= MV_HC_MIN) && (mv_out_o <= MV_MAX);
  endproperty
  a_mv_range: assert property (p_mv_range)
    else $error("MV outside the widest range");

endmodule // pos_top_assertions

bind pos_top pos_top_assertions #(.CYC_PER_CS(CYC_PER_CS)) i_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_req_i(wb_req_i),
  .wb_rsp_o(wb_rsp_o),
  .proc_i(proc_i),
  .heat_out_o(heat_out_o),
  .cool_out_o(cool_out_o),
  .heater_burnout_alarm_o(heater_burnout_alarm_o),
  .valve_open_o(valve_open_o),
  .valve_close_o(valve_close_o),
  .mv_out_o(mv_out_o),
  .setpoint_o(setpoint_o)
);

// ---- testbench/pos_load_model.sv ----
// Heater and cooler load: counts the cycles each drive is switched on.
// Assumes the drives are registered outputs sampled on the rising edge.
`timescale 1ns/100ps
module pos_load_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic heat_i,
  input wire logic cool_i,
  output int heat_cnt_o,
  output int cool_cnt_o
);
  // Heater energy: the bench compares differences, so no clear is needed.
  always_ff @(posedge clk_i) begin
    if (rst_i) heat_cnt_o <= 0;
    else if (heat_i) heat_cnt_o <= heat_cnt_o + 1;
  end

  // Cooler energy, kept apart so both sides can be judged independently.
  always_ff @(posedge clk_i) begin
    if (rst_i) cool_cnt_o <= 0;
    else if (cool_i) cool_cnt_o <= cool_cnt_o + 1;
  end
endmodule // pos_load_model

// ---- testbench/tb_pos_top.sv ----
// Self-checking bench for the output-shaping stage, one task a scenario.
// Assumes a 4-cycle tick, so one second is 400 clock cycles.
`timescale 1ns/100ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
  err_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module tb_pos_top;
  import pos_pkg::*;
  logic clk_i;
  logic rst_i;
  pos_wb_req_t req;
  pos_wb_rsp_t rsp;
  pos_proc_in_t pin;
  logic heat, cool, alarm, vo, vc;
  logic signed [11:0] mv;
  logic signed [15:0] sp;
  int heat_cnt, cool_cnt, err_count, tests_run, h0, c0, n;
  logic [31:0] q;

  ////////////////////////////////////////////////////////////////////////////
  // Short tick keeps pulse periods and ramps within a short run.
  pos_top #(.CYC_PER_CS(4)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(req), .wb_rsp_o(rsp), .proc_i(pin), .heat_out_o(heat),
    .cool_out_o(cool), .heater_burnout_alarm_o(alarm), .valve_open_o(vo),
    .valve_close_o(vc), .mv_out_o(mv), .setpoint_o(sp));
  pos_load_model i_load (.clk_i(clk_i), .rst_i(rst_i), .heat_i(heat),
    .cool_i(cool), .heat_cnt_o(heat_cnt), .cool_cnt_o(cool_cnt));

  // One classic cycle; request held until ack is seen on a rising edge.
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    do begin @(posedge clk_i); k++; end while (rsp.ack !== 1'b1 && k < 50);
    q = rsp.dat;
    req <= '0;
    if (k >= 50) begin err_count++; $display("CHECK FAILED ack none 1 0"); end
  endtask
  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clk_i);
  endtask

  task automatic t_regs();
    logic [7:0] oa[6];
    logic [31:0] ov[6];
    oa = '{OFS_CTRL, OFS_PERIOD, OFS_MVLIM, OFS_MVFIX, OFS_RAMP, OFS_BURNOUT};
    ov = '{CTRL_RST, PERIOD_RST, MVLIM_RST, ZERO_RST, ZERO_RST, ZERO_RST};
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, oa[i], 32'h0);
      `CHK("reset value", ov[i], q)
    end
    wb(1'b1, 8'h30, 32'h0000_1234);
    wb(1'b0, 8'h30, 32'h0);
    `CHK("unmapped", 32'h0000_0000, q)
    $display("done t_regs");
  endtask

  task automatic t_alarm();
    wb(1'b1, OFS_BURNOUT, 32'h0);
    wait_cyc(3);
    `CHK("alarm thr 0", 1'b0, alarm)
    wb(1'b1, OFS_BURNOUT, 32'h64);
    wait_cyc(3);
    `CHK("alarm low", 1'b1, alarm)
    pin.heater_current <= 10'h063;
    wait_cyc(3);
    `CHK("alarm 9.9", 1'b1, alarm)
    pin.heater_current <= 10'h064;
    wait_cyc(3);
    `CHK("alarm 10.0", 1'b0, alarm)
    pin.heater_current <= 10'h3ff;
    wb(1'b1, OFS_BURNOUT, 32'h1f4);
    wait_cyc(3);
    `CHK("alarm thr 50", 1'b1, alarm)
    wb(1'b1, OFS_BURNOUT, 32'h0);
    $display("done t_alarm");
  endtask

  task automatic t_sp();
    wb(1'b1, OFS_CTRL, 32'h0000_0129);
    wb(1'b1, OFS_LSP, 32'h0000_0064);
    pin.remote_setpoint <= 16'h00c8;
    pin.sp_event <= 1'b1;
    wait_cyc(3);
    `CHK("remote sp", 16'h00c8, sp)
    pin.sp_event <= 1'b0;
    wait_cyc(3);
    `CHK("local sp", 16'h0064, sp)
    pin.sp_event <= 1'b1;
    wb(1'b1, OFS_CTRL, 32'h0000_0169);
    wait_cyc(3);
    `CHK("self-tune on", 16'h0064, sp)
    wb(1'b1, OFS_CTRL, 32'h0000_0109);
    wait_cyc(3);
    `CHK("remote off", 16'h0064, sp)
    pin.sp_event <= 1'b0;
    $display("done t_sp");
  endtask

  task automatic t_mv();
    wb(1'b1, OFS_MVLIM, 32'h0064_0320);
    pin.mv_calc <= 12'h384;
    wait_cyc(3);
    `CHK("upper clamp", 12'h320, mv)
    pin.mv_calc <= 12'h032;
    wait_cyc(3);
    `CHK("lower clamp", 12'h064, mv)
    pin.mv_calc <= 12'h1f4;
    wb(1'b1, OFS_MVFIX, 32'hffe2_012c);
    wb(1'b1, OFS_CTRL, 32'h0000_0108);
    wait_cyc(3);
    `CHK("stop mv", 12'h12c, mv)
    pin.input_error <= 1'b1;
    wait_cyc(3);
    `CHK("error mv", 12'hfe2, mv)
    wb(1'b1, OFS_CTRL, 32'h0000_0109);
    pin.input_error <= 1'b0;
    wait_cyc(3);
    `CHK("run mv", 12'h1f4, mv)
    wb(1'b1, OFS_MVLIM, MVLIM_RST);
    $display("done t_mv");
  endtask

  task automatic t_rate();
    wb(1'b1, OFS_RATE, 32'h64);
    pin.mv_calc <= 12'h000;
    wait_cyc(200);
    `CHK("rate half s", 1'b1, mv >= 400)
    wait_cyc(400);
    `CHK("rate 1.5 s", 1'b1, mv >= 300 && mv < 500)
    wait_cyc(1600);
    `CHK("rate end", 12'h000, mv)
    wb(1'b1, OFS_RATE, 32'h0);
    $display("done t_rate");
  endtask

  // Windows are whole periods, so the on-count is exact whatever the phase.
  task automatic t_pulse();
    wb(1'b1, OFS_PERIOD, 32'h0000_0201);
    pin.mv_calc <= 12'h1f4;
    wait_cyc(800);
    h0 = heat_cnt;
    c0 = cool_cnt;
    wait_cyc(800);
    `CHK("std heat on", 400, heat_cnt - h0)
    `CHK("std cool", 0, cool_cnt - c0)
    wb(1'b1, OFS_MVLIM, 32'hfbe6_041a);
    wb(1'b1, OFS_CTRL, 32'h0000_010b);
    pin.mv_calc <= 12'hf06;
    wait_cyc(1600);
    h0 = heat_cnt;
    c0 = cool_cnt;
    wait_cyc(1600);
    `CHK("hc cool on", 400, cool_cnt - c0)
    `CHK("hc heat", 0, heat_cnt - h0)
    wb(1'b1, OFS_CTRL, 32'h0000_010f);
    pin.mv_calc <= 12'h1f4;
    wait_cyc(10);
    h0 = heat_cnt;
    wait_cyc(800);
    `CHK("on/off heat", 800, heat_cnt - h0)
    wb(1'b1, OFS_CTRL, 32'h0000_0109);
    wb(1'b1, OFS_MVLIM, MVLIM_RST);
    $display("done t_pulse");
  endtask

  // Position type: limits ignored while running, valve action on stop.
  task automatic t_valve();
    wb(1'b1, OFS_MVLIM, 32'h0064_0320);
    pin.mv_calc <= 12'h384;
    wb(1'b1, OFS_CTRL, 32'h0000_0219);
    wait_cyc(3);
    `CHK("posprop mv", 12'h384, mv)
    wb(1'b1, OFS_CTRL, 32'h0000_0218);
    wait_cyc(3);
    `CHK("valve open", 2'b10, {vo, vc})
    `CHK("valve pulses", 2'b00, {heat, cool})
    wb(1'b1, OFS_CTRL, 32'h0000_0109);
    wb(1'b1, OFS_MVLIM, MVLIM_RST);
    $display("done t_valve");
  endtask

  task automatic t_ramp();
    wb(1'b1, OFS_LSP, 32'h0);
    wait_cyc(3);
    wb(1'b1, OFS_RAMP, 32'h7);
    wb(1'b1, OFS_LSP, 32'h64);
    n = 0;
    while (sp === 16'h0000 && n < 25000) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("ramp step", 16'h0007, sp)
    wb(1'b1, OFS_CTRL, 32'h0000_0189);
    wait_cyc(24100);
    `CHK("hour unit", 16'h0007, sp)
    wb(1'b1, OFS_RAMP, 32'h0);
    wait_cyc(3);
    `CHK("ramp off", 16'h0064, sp)
    $display("done t_ramp");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Whole run is near 48000 cycles; the watchdog leaves a wide margin.
  initial begin
    repeat (90000) @(posedge clk_i);
    err_count++;
    final_report();
  end

  initial begin
    rst_i = 1'b1;
    req = '0;
    pin = '0;
    err_count = 0;
    tests_run = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_alarm();
    t_sp();
    t_mv();
    t_rate();
    t_pulse();
    t_valve();
    t_ramp();
    final_report();
  end
endmodule // tb_pos_top
